/* File: alu_core_regs.vh */
`ifndef ALU_CORE_REGS_VH
`define ALU_CORE_REGS_VH

// Register byte offsets
`define OFS_CMD 10'h000
`define OFS_ACC 10'h004
`define OFS_STATUS 10'h008
`define OFS_DIR_A 10'h00C
`define OFS_DIR_B 10'h010
`define OFS_DIR_C 10'h014
`define OFS_WD_CTRL 10'h018
`define OFS_WD_COUNT 10'h01C
`define MEM_WINDOW_BIT 9

// Command word fields
`define CMD_OPND_LSB 0
`define CMD_OPND_MSB 7
`define CMD_DEST_BIT 8
`define CMD_OP_LSB 9
`define CMD_OP_MSB 11

// Operation codes
`define OP_SUB 3'h0
`define OP_SUBB 3'h1
`define OP_SWAP 3'h2
`define OP_XOR_IMM 3'h3
`define OP_XOR_REG 3'h4
`define OP_DIR 3'h5
`define OP_SLEEP 3'h6

// Direction load operands
`define DIR_SEL_A 8'h05
`define DIR_SEL_B 8'h06
`define DIR_SEL_C 8'h07

// Status bit positions
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_PWRDN_N 3
`define ST_TMO_N 4
`define ST_BUSY 5
`define ST_SLEEP 6

// Watchdog control bits
`define WD_EN_BIT 0
`define WD_CLR_BIT 1

// Reset values
`define ACC_RESET 8'h00
`define DIR_RESET 8'hFF
`define WD_EN_RESET 1'b0

`endif

/* File: alu_file_mem.v */
`timescale 1ns/1ns
`default_nettype none

module alu_file_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    input wire clock_i,
    input wire [AW-1:0] addr_i,
    input wire we_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o
);

reg [DW-1:0] mem [0:(1<<AW)-1];

// Synchronous write, registered read
always @(posedge clock_i) begin
    if (we_i) begin
        mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
end

endmodule

`default_nettype wire

/* File: alu_calc.v */
`timescale 1ns/1ns
`default_nettype none
`include "alu_core_regs.vh"

module alu_calc (
    input wire [2:0] op_i,
    input wire [7:0] acc_i,
    input wire [7:0] file_i,
    input wire [7:0] imm_i,
    input wire carry_i,
    output reg [7:0] result_o,
    output reg carry_o,
    output reg half_o,
    output wire zero_o
);

reg cin;
reg [8:0] full_sum;
reg [4:0] low_sum;

// Result and flag generation
always @* begin
    cin = 1'b1;
    full_sum = 9'h000;
    low_sum = 5'h00;
    result_o = 8'h00;
    carry_o = carry_i;
    half_o = 1'b0;
    case (op_i)
        `OP_SUB, `OP_SUBB: begin
            // Borrow is the inverted carry
            cin = (op_i == `OP_SUBB) ? carry_i : 1'b1;
            full_sum = {1'b0, file_i} + {1'b0, ~acc_i} + {8'h00, cin};
            low_sum = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + {4'h0, cin};
            result_o = full_sum[7:0];
            carry_o = full_sum[8];
            half_o = low_sum[4];
        end
        `OP_SWAP: begin
            result_o = {file_i[3:0], file_i[7:4]};
        end
        `OP_XOR_IMM: begin
            result_o = acc_i ^ imm_i;
        end
        `OP_XOR_REG: begin
            result_o = acc_i ^ file_i;
        end
        default: begin
            result_o = acc_i;
        end
    endcase
end

// Zero flag from the result
assign zero_o = (result_o == 8'h00);

endmodule

`default_nettype wire

/* File: alu_core.v */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "alu_core_regs.vh"

// Overview of operation
// - Sleep clears the active-low power-down flag and sets the active-low time-out flag.
// - Sleep resets the watchdog counter and its prescaler to zero.
// - Sleep takes no operand and puts the core into its halted-oscillator sleep state.
// - Subtract computes register minus accumulator, result to accumulator when dest is 0, else to register.
// - Subtract with borrow computes register minus accumulator minus inverted carry, result by dest bit.
// - Nibble exchange swaps register nibbles into the destination chosen by dest, flags unchanged.
// - Xor immediate xors the accumulator with an 8-bit literal into the accumulator.
// - Xor register xors accumulator with the register, result to accumulator at dest 0, else register.
// - Direction load copies the accumulator to port A, B or C direction for operand 5, 6 or 7, no flags.
module alu_core #(
    parameter PRE_W = 8,
    parameter WD_W = 8
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire wake_i,
    output wire sleep_o,
    output wire [7:0] port_a_direction_o,
    output wire [7:0] port_b_direction_o,
    output wire [7:0] port_c_direction_o,
    output reg watchdog_timeout_o
);

localparam ST_IDLE = 2'b00;
localparam ST_FETCH = 2'b01;
localparam ST_EXEC = 2'b10;

////////////////////////////////////////////////////////////////////////////////
// State

reg [1:0] state_q;
reg [11:0] cmd_q;
reg [7:0] acc_q;
reg carry_q;
reg half_nibble_flag_q;
reg zero_q;
reg powerdown_flag_n_q;
reg timeout_flag_n_q;
reg sleep_q;
reg [7:0] port_a_direction_q;
reg [7:0] port_b_direction_q;
reg [7:0] port_c_direction_q;
reg wd_en_q;
reg [PRE_W-1:0] wd_prescaler_q;
reg [WD_W-1:0] watchdog_counter_q;
reg mem_wait_q;

wire [2:0] op_w;
wire [7:0] opnd_w;
wire dest_w;
wire [7:0] mem_rdata;
wire [7:0] alu_result;
wire alu_carry;
wire alu_half;
wire alu_zero;

assign op_w = cmd_q[`CMD_OP_MSB:`CMD_OP_LSB];
assign opnd_w = cmd_q[`CMD_OPND_MSB:`CMD_OPND_LSB];
assign dest_w = cmd_q[`CMD_DEST_BIT];

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire bus_req;
wire is_mem;
wire reg_ack;
wire mem_ack;
wire cmd_wr;
wire acc_wr;
wire status_wr;
wire wd_ctrl_wr;
wire busy_w;

// One answer per request, registers one cycle, memory two
assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign is_mem = wb_adr_i[`MEM_WINDOW_BIT];
assign busy_w = (state_q != ST_IDLE);
assign reg_ack = bus_req & ~is_mem;
assign mem_ack = bus_req & is_mem & mem_wait_q;

// Write strobes, low byte lane needed
assign cmd_wr = reg_ack & wb_we_i & (wb_adr_i == `OFS_CMD) & (wb_sel_i[1:0] == 2'b11);
assign acc_wr = reg_ack & wb_we_i & (wb_adr_i == `OFS_ACC) & wb_sel_i[0] & ~busy_w;
assign status_wr = reg_ack & wb_we_i & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0] & ~busy_w;
assign wd_ctrl_wr = reg_ack & wb_we_i & (wb_adr_i == `OFS_WD_CTRL) & wb_sel_i[0];

////////////////////////////////////////////////////////////////////////////////
// Register file

wire mem_we;
wire [6:0] mem_addr;
wire [7:0] mem_wdata;
wire exec_file_wr;

// Register destination for ops that write back
assign exec_file_wr = (state_q == ST_EXEC) & dest_w &
    ((op_w == `OP_SUB) | (op_w == `OP_SUBB) | (op_w == `OP_SWAP) | (op_w == `OP_XOR_REG));
assign mem_addr = busy_w ? opnd_w[6:0] : wb_adr_i[8:2];
assign mem_we = exec_file_wr | (mem_ack & wb_we_i & wb_sel_i[0]);
assign mem_wdata = busy_w ? alu_result : wb_dat_i[7:0];

alu_file_mem #(
    .AW(7),
    .DW(8)
) u_file_mem (
    .clock_i(clock_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
);

alu_calc u_calc (
    .op_i(op_w),
    .acc_i(acc_q),
    .file_i(mem_rdata),
    .imm_i(opnd_w),
    .carry_i(carry_q),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .half_o(alu_half),
    .zero_o(alu_zero)
);

////////////////////////////////////////////////////////////////////////////////
// Bus answer

reg [31:0] rdata_d;

// Read multiplexer
always @* begin
    rdata_d = 32'h00000000;
    if (is_mem) begin
        rdata_d = {24'h000000, mem_rdata};
    end else begin
        case (wb_adr_i)
            `OFS_CMD: rdata_d = {20'h00000, cmd_q};
            `OFS_ACC: rdata_d = {24'h000000, acc_q};
            `OFS_STATUS: rdata_d = {25'h0000000, sleep_q, busy_w, timeout_flag_n_q,
                powerdown_flag_n_q, zero_q, half_nibble_flag_q, carry_q};
            `OFS_DIR_A: rdata_d = {24'h000000, port_a_direction_q};
            `OFS_DIR_B: rdata_d = {24'h000000, port_b_direction_q};
            `OFS_DIR_C: rdata_d = {24'h000000, port_c_direction_q};
            `OFS_WD_CTRL: rdata_d = {31'h00000000, wd_en_q};
            `OFS_WD_COUNT: rdata_d = {{(16-PRE_W){1'b0}}, wd_prescaler_q,
                {(16-WD_W){1'b0}}, watchdog_counter_q};
            default: rdata_d = 32'h00000000;
        endcase
    end
end

// Ack and read data, memory waits for an idle core
always @(posedge clock_i) begin
    if (!rst_n_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        mem_wait_q <= 1'b0;
    end else begin
        wb_ack_o <= reg_ack | mem_ack;
        if (reg_ack | mem_ack) begin
            wb_dat_o <= rdata_d;
        end
        if (mem_ack) begin
            mem_wait_q <= 1'b0;
        end else if (bus_req & is_mem & ~busy_w) begin
            mem_wait_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

wire sleep_exec;
wire wd_tick;
wire wd_wrap;

assign sleep_exec = (state_q == ST_EXEC) & (op_w == `OP_SLEEP);

// Command taken only when idle and awake
always @(posedge clock_i) begin
    if (!rst_n_i) begin
        state_q <= ST_IDLE;
        cmd_q <= 12'h000;
    end else begin
        case (state_q)
            ST_IDLE: begin
                if (cmd_wr & ~sleep_q) begin
                    cmd_q <= wb_dat_i[11:0];
                    state_q <= ST_FETCH;
                end
            end
            ST_FETCH: state_q <= ST_EXEC;
            ST_EXEC: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Accumulator and arithmetic flags

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        acc_q <= `ACC_RESET;
        carry_q <= 1'b0;
        half_nibble_flag_q <= 1'b0;
        zero_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
        case (op_w)
            `OP_SUB, `OP_SUBB: begin
                if (!dest_w) begin
                    acc_q <= alu_result;
                end
                carry_q <= alu_carry;
                half_nibble_flag_q <= alu_half;
                zero_q <= alu_zero;
            end
            `OP_SWAP: begin
                if (!dest_w) begin
                    acc_q <= alu_result;
                end
            end
            `OP_XOR_IMM: begin
                acc_q <= alu_result;
                zero_q <= alu_zero;
            end
            `OP_XOR_REG: begin
                if (!dest_w) begin
                    acc_q <= alu_result;
                end
                zero_q <= alu_zero;
            end
            default: begin
                acc_q <= acc_q;
            end
        endcase
    end else begin
        if (acc_wr) begin
            acc_q <= wb_dat_i[7:0];
        end
        if (status_wr) begin
            carry_q <= wb_dat_i[`ST_CARRY];
            half_nibble_flag_q <= wb_dat_i[`ST_HALF];
            zero_q <= wb_dat_i[`ST_ZERO];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Port direction registers

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        port_a_direction_q <= `DIR_RESET;
        port_b_direction_q <= `DIR_RESET;
        port_c_direction_q <= `DIR_RESET;
    end else if ((state_q == ST_EXEC) & (op_w == `OP_DIR)) begin
        // Other operands leave every port untouched
        case (opnd_w)
            `DIR_SEL_A: port_a_direction_q <= acc_q;
            `DIR_SEL_B: port_b_direction_q <= acc_q;
            `DIR_SEL_C: port_c_direction_q <= acc_q;
            default: port_a_direction_q <= port_a_direction_q;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Watchdog

assign wd_tick = wd_en_q & (&wd_prescaler_q);
assign wd_wrap = wd_tick & (&watchdog_counter_q);

// Counter and prescaler, sleep clear wins over counting
always @(posedge clock_i) begin
    if (!rst_n_i) begin
        wd_en_q <= `WD_EN_RESET;
        wd_prescaler_q <= {PRE_W{1'b0}};
        watchdog_counter_q <= {WD_W{1'b0}};
        watchdog_timeout_o <= 1'b0;
    end else begin
        watchdog_timeout_o <= wd_wrap & ~sleep_exec;
        if (wd_ctrl_wr) begin
            wd_en_q <= wb_dat_i[`WD_EN_BIT];
        end
        if (sleep_exec | (wd_ctrl_wr & wb_dat_i[`WD_CLR_BIT])) begin
            wd_prescaler_q <= {PRE_W{1'b0}};
            watchdog_counter_q <= {WD_W{1'b0}};
        end else if (wd_en_q) begin
            wd_prescaler_q <= wd_prescaler_q + {{(PRE_W-1){1'b0}}, 1'b1};
            if (wd_tick) begin
                watchdog_counter_q <= watchdog_counter_q + {{(WD_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power status and sleep state

// Sleep sets win over wake and time-out in the same cycle
always @(posedge clock_i) begin
    if (!rst_n_i) begin
        powerdown_flag_n_q <= 1'b1;
        timeout_flag_n_q <= 1'b1;
        sleep_q <= 1'b0;
    end else if (sleep_exec) begin
        powerdown_flag_n_q <= 1'b0;
        timeout_flag_n_q <= 1'b1;
        sleep_q <= 1'b1;
    end else begin
        if (wd_wrap) begin
            timeout_flag_n_q <= 1'b0;
        end
        if (wake_i | wd_wrap) begin
            sleep_q <= 1'b0;
        end
    end
end

// Oscillator halt request
assign sleep_o = sleep_q;
assign port_a_direction_o = port_a_direction_q;
assign port_b_direction_o = port_b_direction_q;
assign port_c_direction_o = port_c_direction_q;

endmodule

`default_nettype wire

/* File: alu_core_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alu_core_regs.vh"
module alu_core_chk #(
    parameter PRE_W = 8,
    parameter WD_W = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wake_i,
    input wire logic sleep_o,
    input wire logic [7:0] port_a_direction_o,
    input wire logic [7:0] port_b_direction_o,
    input wire logic [7:0] port_c_direction_o,
    input wire logic watchdog_timeout_o
);
    logic cmd_wr;
    logic [2:0] slp_q, slp_d, dir_q, dir_d;
    ////////////////////////////////////////////////////////////////////////
    // Command write taken, ages of last sleep and direction commands
    assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `OFS_CMD && wb_sel_i[1:0] == 2'b11;
    assign slp_d = (cmd_wr && wb_dat_i[11:9] == `OP_SLEEP) ? 3'h0 : ((slp_q == 3'h7) ? slp_q : slp_q + 3'h1);
    assign dir_d = (cmd_wr && wb_dat_i[11:9] == `OP_DIR) ? 3'h0 : ((dir_q == 3'h7) ? dir_q : dir_q + 3'h1);
    // Age counters
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            slp_q <= 3'h7;
            dir_q <= 3'h7;
        end else begin
            slp_q <= slp_d;
            dir_q <= dir_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sleep_enter_a: assert property (cmd_wr && wb_dat_i[11:9] == `OP_SLEEP && !sleep_o |-> ##[1:4] sleep_o)
        else $error("sleep command did not enter sleep");
    sleep_cause_a: assert property ($rose(sleep_o) |-> slp_q <= 3'h4)
        else $error("sleep entered without command");
    sleep_hold_a: assert property (sleep_o && !wake_i |=> sleep_o || watchdog_timeout_o)
        else $error("sleep left without cause");
    wake_end_a: assert property (sleep_o && wake_i |=> !sleep_o)
        else $error("wake did not end sleep");
    wd_quiet_a: assert property ($rose(sleep_o) |=> !watchdog_timeout_o [*8])
        else $error("watchdog not cleared by sleep");
    tmo_end_a: assert property (watchdog_timeout_o |-> !sleep_o ##1 !watchdog_timeout_o)
        else $error("timeout pulse wrong");
    dir_cause_a: assert property ($changed({port_a_direction_o, port_b_direction_o, port_c_direction_o}) |->
        dir_q <= 3'h4)
        else $error("direction changed without command");
    dir_one_a: assert property ($onehot0({$changed(port_a_direction_o), $changed(port_b_direction_o),
        $changed(port_c_direction_o)}))
        else $error("several directions changed");
endmodule
bind alu_core alu_core_chk #(.PRE_W(PRE_W), .WD_W(WD_W)) chk_i (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wake_i, .sleep_o, .port_a_direction_o,
    .port_b_direction_o, .port_c_direction_o, .watchdog_timeout_o);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alu_core_regs.vh"
module tb_top;
    logic clock_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wake_i = 0;
    logic [9:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic wb_ack_o, sleep_o, watchdog_timeout_o, d, cin;
    logic [7:0] port_a_direction_o, port_b_direction_o, port_c_direction_o, acc, v, r, imm;
    logic [7:0] dirs [3];
    logic [4:0] st, h;
    logic [8:0] t;
    logic [2:0] op;
    logic [6:0] f;
    int error_cnt = 0, n_compared = 0, seed = 32'h9c66, k;
    ////////////////////////////////////////////////////////////////////////
    // Clock and device
    always #5 clock_i = ~clock_i;
    alu_core #(.PRE_W(2), .WD_W(2)) uut (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wake_i, .sleep_o, .port_a_direction_o, .port_b_direction_o,
        .port_c_direction_o, .watchdog_timeout_o);
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Classic single Wishbone cycle, result in q
    task wb(input logic we, input logic [9:0] a, input logic [31:0] dat);
        int n;
        @(posedge clock_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (n >= 40) begin
            error_cnt++;
            $display("BAD %0t no ack", $time);
            end_sim;
        end
    endtask
    task cmd(input logic [2:0] o, input logic dd, input logic [7:0] p);
        wb(1, `OFS_CMD, {20'h0, o, dd, p});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1;
        st = 5'h18;
        dirs = '{8'hFF, 8'hFF, 8'hFF};
        wb(0, `OFS_STATUS, 0);
        ck(q, st);
        for (k = 0; k < 60; k++) begin
            op = {$random(seed)} % 5;
            {f, v, acc, imm, d, st[2:0]} = {$random(seed), $random(seed)};
            if (k % 8 == 0) v = acc;
            wb(1, 10'h200 + {f, 2'b0}, v);
            wb(1, `OFS_ACC, acc);
            wb(1, `OFS_STATUS, st[2:0]);
            cmd(op, d, (op == `OP_XOR_IMM) ? imm : {1'b0, f});
            cin = (op == `OP_SUBB) ? st[0] : 1'b1;
            t = v + {1'b0, ~acc} + cin;
            h = v[3:0] + {1'b0, ~acc[3:0]} + cin;
            case (op)
                `OP_SUB, `OP_SUBB: begin
                    r = t[7:0];
                    st[2:0] = {r == 0, h[4], t[8]};
                end
                `OP_SWAP: r = {v[3:0], v[7:4]};
                `OP_XOR_IMM: r = acc ^ imm;
                default: r = acc ^ v;
            endcase
            if (op > `OP_SWAP) st[2] = (r == 0);
            if (d && op != `OP_XOR_IMM) v = r;
            else acc = r;
            wb(0, `OFS_ACC, 0);
            ck(q, acc);
            wb(0, `OFS_STATUS, 0);
            ck(q, st);
            wb(0, 10'h200 + {f, 2'b0}, 0);
            ck(q, v);
        end
        // Direction loads, operand 4 ignored
        for (k = 4; k < 8; k++) begin
            acc = $random(seed);
            wb(1, `OFS_ACC, acc);
            cmd(`OP_DIR, 0, k[7:0]);
            if (k > 4) dirs[k-5] = acc;
            wb(0, `OFS_STATUS, 0);
            ck(q, st);
            ck({port_c_direction_o, port_b_direction_o, port_a_direction_o}, {dirs[2], dirs[1], dirs[0]});
        end
        // Run watchdog, freeze it, then sleep
        wb(1, `OFS_WD_CTRL, 1);
        repeat (20) @(posedge clock_i);
        wb(1, `OFS_WD_CTRL, 0);
        cmd(`OP_SLEEP, 0, $random(seed));
        st[4:3] = 2'b10;
        wb(0, `OFS_STATUS, 0);
        ck(q, st | 32'h40);
        wb(0, `OFS_WD_COUNT, 0);
        ck(q, 0);
        ck(sleep_o, 1);
        // Asleep: a command is dropped
        cmd(`OP_XOR_IMM, 0, 8'hFF);
        @(posedge clock_i);
        wake_i <= 1;
        @(posedge clock_i);
        wake_i <= 0;
        // Awake: a no-op command changes nothing
        cmd(3'h7, 1, 8'hFF);
        wb(0, `OFS_STATUS, 0);
        ck(q, st);
        wb(0, `OFS_ACC, 0);
        ck(q, acc);
        // Sleep with watchdog running until wrap
        wb(1, `OFS_WD_CTRL, 1);
        cmd(`OP_SLEEP, 1, 0);
        k = 0;
        while (watchdog_timeout_o !== 1'b1 && k < 40) begin
            @(posedge clock_i);
            k++;
        end
        // Sleep edge, 15 more watchdog steps, registered pulse, sample
        ck(k, 32'h12);
        ck(sleep_o, 0);
        // Mid-run reset restores directions, status and accumulator
        rst_n_i <= 0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1;
        ck({port_c_direction_o, port_b_direction_o, port_a_direction_o}, 24'hFFFFFF);
        wb(0, `OFS_STATUS, 0);
        ck(q, 32'h18);
        wb(0, `OFS_ACC, 0);
        ck(q, 0);
        end_sim;
    end
endmodule
`default_nettype wire
